// [rtl/bit_sync.sv]
`timescale 1ns/10ps
module bit_sync #(
  parameter int W = 1
) (
  // sampling clock
  input  wire logic         clk,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // two stage synchroniser, first stage read only by the second
  always_ff @(posedge clk) begin
    meta_r <= din;
    dout   <= meta_r;
  end
endmodule

// [rtl/nx_ds0_data_slot_mapper.sv]
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
// How it works
// - channel type picks a 56 or 64 kbit/s root rate for every slot
// - reported rate is slot count times root rate, up to 1344 or 1536
// - start slot accepts 1 to 24 and marks the first data slot
// - slot count may reach at most the slots from start through 24
// - slots are contiguous upward from start and never wrap past 24
// - overlap with slots used by other channels shows in status
// - direction sends all data slots to east or west, never both
// - clock source picks internal gapped clock or external port clock
module nx_ds0_data_slot_mapper
  import nx_ds0_pkg::*;
(
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // t1 bit clock and frame timing
  input  wire logic        linkClk,
  input  wire logic        frameSync,
  // dte port pins
  input  wire logic        dteTxData,
  input  wire logic        dteExtClk,
  output logic             dteIntClk,
  // t1 line insertion
  output logic             eastTxData,
  output logic             eastSlotActive,
  output logic             westTxData,
  output logic             westSlotActive
);

  // byte lane merge for register writes
  function automatic logic [31:0] beMerge(input logic [31:0] oldV,
                                          input logic [31:0] newV,
                                          input logic [3:0]  be);
    logic [31:0] res;
    res = oldV;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) res[b*8 +: 8] = newV[b*8 +: 8];
    end
    return res;
  endfunction

  bus_state_e          busState_r;
  logic [`CTRL_MSB:0]  ctrl_r;
  logic [4:0]          start_r;
  logic [4:0]          count_r;
  slot_mask_t          eastUsed_r;
  slot_mask_t          westUsed_r;
  logic                underSticky_r;
  logic                wrFire;
  logic [31:0]         merged;
  logic [31:0]         rdValue;
  slot_mask_t          maskNow;
  logic                validNow;
  slot_mask_t          usedSel;
  slot_mask_t          conflict;
  logic [10:0]         rootNow;
  logic [10:0]         rateNow;
  logic                cfgWrite;
  link_cfg_s           linkNext;
  link_cfg_s           xfer_r;
  logic                reqTog_r;
  logic                busy_r;
  logic                dirty_r;
  logic                ackSync;
  logic                underSync;
  logic                underSeen_r;
  logic                underEdge;
  logic [`LINK_HOLD_MSB:0] rstHold_r;
  logic                linkGo;

  // bus handshake: request seen, then one cycle with waitrequest low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busState_r  <= BUS_WAIT;
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else if (busState_r == BUS_WAIT) begin
      if (read || write) begin
        busState_r  <= BUS_ANSWER;
        waitrequest <= 1'b0;
        readdata    <= read ? rdValue : 32'h00000000;
      end
    end else begin
      busState_r  <= BUS_WAIT;
      waitrequest <= 1'b1;
    end
  end

  assign wrFire   = write && (busState_r == BUS_ANSWER);
  assign cfgWrite = wrFire && ((address == `REG_CTRL) || (address == `REG_SLOT));

  // byte merge onto the current word, the read decode serves both
  assign merged = beMerge(rdValue, writedata, byteenable);

  // configuration registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r     <= `CTRL_RST;
      start_r    <= `START_RST;
      count_r    <= `COUNT_RST;
      eastUsed_r <= '0;
      westUsed_r <= '0;
    end else if (wrFire) begin
      if (address == `REG_CTRL) begin
        ctrl_r <= merged[`CTRL_MSB:0];
      end else if (address == `REG_SLOT) begin
        start_r <= merged[`SLOT_START_MSB:`SLOT_START_LSB];
        count_r <= merged[`SLOT_COUNT_MSB:`SLOT_COUNT_LSB];
      end else if (address == `REG_EAST_USED) begin
        eastUsed_r <= merged[`SLOT_MSB:0];
      end else if (address == `REG_WEST_USED) begin
        westUsed_r <= merged[`SLOT_MSB:0];
      end
    end
  end

  // slot run from start and count, empty when out of range
  slot_window window (
    .start (start_r),
    .count (count_r),
    .mask  (maskNow),
    .valid (validNow)
  );

  // overlap with the other channels on the selected line
  assign usedSel  = ctrl_r[`CTRL_WEST] ? westUsed_r : eastUsed_r;
  assign conflict = ctrl_r[`CTRL_EN] ? (maskNow & usedSel) : '0;

  // aggregate rate in kbit/s
  assign rootNow = ctrl_r[`CTRL_CH64] ? `ROOT_64 : `ROOT_56;
  assign rateNow = validNow ? 11'(count_r * rootNow) : 11'h000;

  // read decode, unmapped reads give zero
  always_comb begin
    if (address == `REG_CTRL) begin
      rdValue = {28'h0000000, ctrl_r};
    end else if (address == `REG_SLOT) begin
      rdValue = {19'h00000, count_r, 3'h0, start_r};
    end else if (address == `REG_EAST_USED) begin
      rdValue = {8'h00, eastUsed_r};
    end else if (address == `REG_WEST_USED) begin
      rdValue = {8'h00, westUsed_r};
    end else if (address == `REG_STATUS) begin
      rdValue = {5'h00, underSticky_r, (busy_r || dirty_r), !validNow, conflict};
    end else if (address == `REG_RATE) begin
      rdValue = {21'h000000, rateNow};
    end else begin
      rdValue = 32'h00000000;
    end
  end

  // settings seen by the link, disabled or invalid runs map no slot
  always_comb begin
    linkNext        = '0;
    linkNext.chan64 = ctrl_r[`CTRL_CH64];
    linkNext.west   = ctrl_r[`CTRL_WEST];
    linkNext.extClk = ctrl_r[`CTRL_EXT];
    linkNext.mask   = ctrl_r[`CTRL_EN] ? maskNow : '0;
  end

  // stretched link reset, so the slow link clock sees several edges in reset
  always_ff @(posedge clk) begin
    if (!resetn) rstHold_r <= '0;
    else if (!linkGo) rstHold_r <= rstHold_r + 1'b1;
  end

  assign linkGo = rstHold_r[`LINK_HOLD_MSB]; // flop bit, no logic

  // config handshake launch, word held stable until acknowledged
  always_ff @(posedge clk) begin
    if (!resetn) begin
      xfer_r   <= '0;
      reqTog_r <= 1'b0;
      busy_r   <= 1'b0;
    end else if (busy_r) begin
      if (ackSync == reqTog_r) busy_r <= 1'b0;
    end else if (dirty_r && linkGo) begin
      xfer_r   <= linkNext;
      reqTog_r <= ~reqTog_r;
      busy_r   <= 1'b1;
    end
  end

  // pending change, a new write wins over the launch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dirty_r <= 1'b1;
    end else if (cfgWrite) begin
      dirty_r <= 1'b1;
    end else if (!busy_r && linkGo) begin
      dirty_r <= 1'b0;
    end
  end

  // underrun event from the link, set wins over clear
  assign underEdge = underSync ^ underSeen_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      underSeen_r   <= 1'b0;
      underSticky_r <= 1'b0;
    end else begin
      underSeen_r <= underSync;
      if (underEdge) begin
        underSticky_r <= 1'b1;
      end else if (wrFire && (address == `REG_STATUS) && byteenable[3]
                   && writedata[`STAT_UNDER]) begin
        underSticky_r <= 1'b0;
      end
    end
  end

  // ---- link domain ----

  logic       linkRstn;
  logic       reqSync;
  logic       reqSeen_r;
  link_cfg_s  linkCfg_r;
  logic [1:0] pinSync;
  logic       dataSync;
  logic       extSync;
  logic       extPrev_r;
  logic       extEdge;
  logic [2:0] bitPos_r;
  logic [4:0] slotPos_r;
  logic       inFrame_r;
  logic       slotHit;
  logic       fillBit;
  logic       dataPos;
  logic       lineBit;
  logic       holdBit_r;
  logic       fresh_r;
  logic       underTog_r;

  // crossings in both directions
  bit_sync #(.W(1)) rstCross   (.clk(linkClk), .din(linkGo),     .dout(linkRstn));
  bit_sync #(.W(1)) reqCross   (.clk(linkClk), .din(reqTog_r),   .dout(reqSync));
  bit_sync #(.W(1)) ackCross   (.clk(clk),     .din(reqSeen_r),  .dout(ackSync));
  bit_sync #(.W(1)) underCross (.clk(clk),     .din(underTog_r), .dout(underSync));
  bit_sync #(.W(2)) pinCross   (.clk(linkClk), .din({dteExtClk, dteTxData}),
                                .dout(pinSync));

  assign dataSync = pinSync[0];
  assign extSync  = pinSync[1];
  assign extEdge  = extSync && !extPrev_r;

  // config capture on request toggle, echoed back as acknowledge
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      reqSeen_r <= 1'b0;
      linkCfg_r <= '0;
    end else if (reqSync != reqSeen_r) begin
      reqSeen_r <= reqSync;
      linkCfg_r <= xfer_r;
    end
  end

  // slot and bit position from the framing bit
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      bitPos_r  <= 3'h0;
      slotPos_r <= 5'h00;
      inFrame_r <= 1'b0;
    end else if (frameSync) begin
      bitPos_r  <= 3'h0;
      slotPos_r <= 5'h00;
      inFrame_r <= 1'b1;
    end else if (inFrame_r) begin
      bitPos_r <= bitPos_r + 3'h1;
      if (bitPos_r == `LAST_BIT) begin
        if (slotPos_r == `LAST_SLOT) inFrame_r <= 1'b0;
        else slotPos_r <= slotPos_r + 5'h01;
      end
    end
  end

  assign slotHit = inFrame_r && linkCfg_r.mask[slotPos_r];
  assign fillBit = !linkCfg_r.chan64 && (bitPos_r == `LAST_BIT);
  assign dataPos = slotHit && !fillBit;
  assign lineBit = fillBit ? 1'b1 : holdBit_r;

  // line insertion, one line only, idle ones elsewhere
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      eastSlotActive <= 1'b0;
      eastTxData     <= 1'b1;
      westSlotActive <= 1'b0;
      westTxData     <= 1'b1;
    end else begin
      eastSlotActive <= slotHit && !linkCfg_r.west;
      eastTxData     <= (slotHit && !linkCfg_r.west) ? lineBit : 1'b1;
      westSlotActive <= slotHit && linkCfg_r.west;
      westTxData     <= (slotHit && linkCfg_r.west) ? lineBit : 1'b1;
    end
  end

  // dte sampling, internal gapped clock or external port clock
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      dteIntClk <= 1'b0;
      extPrev_r <= 1'b0;
      holdBit_r <= 1'b1;
    end else begin
      dteIntClk <= dataPos && !linkCfg_r.extClk;
      extPrev_r <= extSync;
      if (linkCfg_r.extClk ? extEdge : dataPos) holdBit_r <= dataSync;
    end
  end

  // fresh bit bookkeeping, a missing external bit toggles underrun
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      fresh_r    <= 1'b0;
      underTog_r <= 1'b0;
    end else begin
      if (extEdge) fresh_r <= 1'b1;
      else if (dataPos) fresh_r <= 1'b0;
      if (dataPos && linkCfg_r.extClk && !fresh_r && !extEdge) begin
        underTog_r <= ~underTog_r;
      end
    end
  end

  // ---- checks ----

  chk_rate_read: assert property (@(posedge clk) disable iff (!resetn)
    (busState_r == BUS_ANSWER) && read && (address == `REG_RATE)
    |-> readdata[10:0] == (validNow ? count_r * (ctrl_r[`CTRL_CH64] ? 64 : 56) : 0))
    else $error("rate reads wrong");

  chk_start_range: assert property (@(posedge clk) disable iff (!resetn)
    ((start_r == 5'h00) || (start_r > 5'h18)) |-> (maskNow == '0))
    else $error("slots mapped with bad start");

  chk_count_limit: assert property (@(posedge clk) disable iff (!resetn)
    ({1'b0, start_r} + {1'b0, count_r} > 6'h19) |-> (maskNow == '0) && !validNow)
    else $error("run beyond slot 24 accepted");

  chk_mask_contig: assert property (@(posedge clk) disable iff (!resetn)
    validNow |-> maskNow == slot_mask_t'(((25'h1 << count_r) - 25'h1) << (start_r - 5'h01)))
    else $error("slot run not contiguous");

  chk_conflict_flag: assert property (@(posedge clk) disable iff (!resetn)
    (busState_r == BUS_WAIT) && read && (address == `REG_STATUS) && ctrl_r[`CTRL_EN]
    |=> readdata[`SLOT_MSB:0] == $past(maskNow & usedSel))
    else $error("conflict not reported");

  chk_config_handoff: assert property (@(posedge clk) disable iff (!resetn)
    $rose(busy_r) |-> ##[1:60] !busy_r)
    else $error("config handshake stuck");

  chk_one_line: assert property (@(posedge linkClk) disable iff (!linkRstn || !linkGo)
    !(eastSlotActive && westSlotActive))
    else $error("both lines active");

  chk_fill_bit: assert property (@(posedge linkClk) disable iff (!linkRstn || !linkGo)
    slotHit && fillBit |=> (eastSlotActive ? eastTxData : westTxData))
    else $error("56 mode fill bit not one");

  chk_root_data: assert property (@(posedge linkClk) disable iff (!linkRstn || !linkGo)
    slotHit && linkCfg_r.chan64 && (bitPos_r == `LAST_BIT)
    |=> (eastSlotActive ? eastTxData : westTxData) == $past(holdBit_r))
    else $error("64 mode eighth bit not data");

  chk_int_clock: assert property (@(posedge linkClk) disable iff (!linkRstn || !linkGo)
    (linkCfg_r.extClk && $stable(linkCfg_r.extClk)) |-> !dteIntClk)
    else $error("internal clock runs in external mode");

  cov_conflict:  cover property (@(posedge clk) disable iff (!resetn) |conflict);
  cov_underrun:  cover property (@(posedge clk) disable iff (!resetn) underEdge);
  cov_west_fill: cover property (@(posedge linkClk) disable iff (!linkRstn || !linkGo)
    westSlotActive && !linkCfg_r.chan64);
  cov_last_slot: cover property (@(posedge linkClk) disable iff (!linkRstn || !linkGo)
    slotHit && (slotPos_r == `LAST_SLOT));

endmodule

// [rtl/nx_ds0_defs.svh]
`ifndef NX_DS0_DEFS_SVH
`define NX_DS0_DEFS_SVH

// register byte offsets
`define REG_CTRL       5'h00
`define REG_SLOT       5'h04
`define REG_EAST_USED  5'h08
`define REG_WEST_USED  5'h0C
`define REG_STATUS     5'h10
`define REG_RATE       5'h14

// control field positions
`define CTRL_EN        0
`define CTRL_CH64      1
`define CTRL_WEST      2
`define CTRL_EXT       3
`define CTRL_MSB       3

// slot register fields
`define SLOT_START_LSB 0
`define SLOT_START_MSB 4
`define SLOT_COUNT_LSB 8
`define SLOT_COUNT_MSB 12

// status field positions
`define STAT_INVALID   24
`define STAT_BUSY      25
`define STAT_UNDER     26

// reset values
`define CTRL_RST       4'h0
`define START_RST      5'h01
`define COUNT_RST      5'h01

// frame geometry and root rates
`define SLOT_MSB       23
`define SLOT_FIRST     6'h01
`define SLOT_LIMIT     6'h19
`define LAST_SLOT      5'h17
`define LAST_BIT       3'h7
`define ROOT_56        11'h038
`define ROOT_64        11'h040

// link reset stretch, released after two to this power system clocks
`define LINK_HOLD_MSB  5

`endif

// [rtl/nx_ds0_pkg.sv]
package nx_ds0_pkg;
  `include "nx_ds0_defs.svh"

  // one bit per ds0 slot, bit 0 is slot 1
  typedef logic [`SLOT_MSB:0] slot_mask_t;

  // settings handed to the link domain
  typedef struct packed {
    logic       chan64;
    logic       west;
    logic       extClk;
    slot_mask_t mask;
  } link_cfg_s;

  // bus answer phases
  typedef enum logic {
    BUS_WAIT,
    BUS_ANSWER
  } bus_state_e;
endpackage

// [rtl/slot_window.sv]
`timescale 1ns/10ps
module slot_window
  import nx_ds0_pkg::*;
(
  // requested start slot and slot count
  input  wire logic [4:0] start,
  input  wire logic [4:0] count,
  // resulting slot mask and validity
  output slot_mask_t      mask,
  output logic            valid
);
  logic [5:0] first;
  logic [5:0] stop;

  // contiguous run that must end at or before slot 24
  always_comb begin
    first = {1'b0, start};
    stop  = first + {1'b0, count};
    valid = (first >= `SLOT_FIRST) && (count != 5'h00) && (stop <= `SLOT_LIMIT);
    mask  = '0;
    for (int i = 0; i <= `SLOT_MSB; i++) begin
      mask[i] = valid && (6'(i + 1) >= first) && (6'(i + 1) < stop);
    end
  end
endmodule

// [testbench/dte_model.sv]
`timescale 1ns/10ps
module dte_model (
  // link timing seen by the dte
  input  wire logic linkClk,
  input  wire logic lineTiming,
  // settings from the bench
  input  wire logic extMode,
  input  wire logic txLevel,
  // port pins
  output logic      dteTxData,
  output logic      dteExtClk
);
  initial begin
    dteTxData = 1'b1;
    dteExtClk = 1'b0;
  end

  // loops line timing back as the transmit clock; stands still between slots
  always @(posedge linkClk) begin
    dteExtClk <= extMode & lineTiming;
    dteTxData <= txLevel;
  end
endmodule

// [testbench/nx_ds0_data_slot_mapper_bench.sv]
`timescale 1ns/10ps
`include "nx_ds0_defs.svh"
module nx_ds0_data_slot_mapper_bench;
  import nx_ds0_pkg::*;

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        linkClk = 1'b0;
  logic        frameSync = 1'b0;
  logic        dteTxData, dteExtClk, dteIntClk;
  logic        eastTxData, eastSlotActive, westTxData, westSlotActive;
  logic        extMode = 1'b0;
  logic        txLevel = 1'b0;
  int          nMismatch = 0;
  int          nChecks = 0;
  int          cnt = 0;
  int          pulses = 0;
  int          frPulses = 0;
  int          mStart, mCount, pos, slotN, bitN;
  logic        mCh64, mWest, monOn = 1'b0;
  logic        inMap, dBit;
  logic [31:0] rd;

  always #2.5 clk = ~clk;
  // link clock of unrelated phase
  initial begin
    #7;
    forever #16 linkClk = ~linkClk;
  end

  // frame timing: sync pulse then 192 slot bits
  always @(posedge linkClk) begin
    cnt       <= (cnt == 192) ? 0 : cnt + 1;
    frameSync <= (cnt == 192);
  end

  nx_ds0_data_slot_mapper nx_ds0_data_slot_mapper_i (
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .linkClk(linkClk), .frameSync(frameSync),
    .dteTxData(dteTxData), .dteExtClk(dteExtClk), .dteIntClk(dteIntClk),
    .eastTxData(eastTxData), .eastSlotActive(eastSlotActive),
    .westTxData(westTxData), .westSlotActive(westSlotActive));

  dte_model dte_model_i (
    .linkClk(linkClk), .lineTiming(eastSlotActive | westSlotActive),
    .extMode(extMode), .txLevel(txLevel), .dteTxData(dteTxData), .dteExtClk(dteExtClk));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (nMismatch == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task automatic busCycle(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    if (i >= 50) chk("busAnswer", 32'h1, 32'h0);
  endtask

  // program a channel and wait for the link handoff
  task automatic cfg(input logic en, ch64, west, ext, input int st, cn);
    int i;
    busCycle(1'b1, `REG_CTRL, {28'h0, ext, west, ch64, en});
    busCycle(1'b1, `REG_SLOT, {19'h0, 5'(cn), 3'h0, 5'(st)});
    mStart = st;
    mCount = cn;
    mCh64  = ch64;
    mWest  = west;
    extMode <= ext;
    i = 0;
    do begin
      busCycle(1'b0, `REG_STATUS, 32'h0);
      i++;
    end while (rd[`STAT_BUSY] !== 1'b0 && i < 40);
    chk("cfgDone", rd[`STAT_BUSY], 32'h0);
  endtask

  // watch the line outputs for two frames after settling
  task automatic linkRun(input int expPulses);
    repeat (2600) @(posedge clk);
    monOn = 1'b1;
    repeat (2500) @(posedge clk);
    monOn = 1'b0;
    chk("pulsesPerFrame", frPulses, expPulses);
  endtask

  // line monitor: output in cycle cnt reflects position cnt-1
  always @(negedge linkClk) begin
    pulses = pulses + (dteIntClk === 1'b1);
    if (cnt == 1) begin
      frPulses = pulses;
      pulses = 0;
    end
    pos = (cnt == 0) ? 192 : cnt - 1;
    if (monOn && pos >= 1) begin
      slotN = (pos - 1) / 8 + 1;
      bitN  = (pos - 1) % 8;
      inMap = slotN >= mStart && slotN < mStart + mCount;
      dBit  = inMap && (mCh64 || bitN != 7);
      if (inMap && !mCh64 && bitN == 7) begin
        chk("bitEight", mWest ? westTxData : eastTxData, 32'h1);
        chk("fillAct", mWest ? westSlotActive : eastSlotActive, 32'h1);
      end else begin
        chk("eastAct", eastSlotActive, dBit & !mWest);
        chk("westAct", westSlotActive, dBit & mWest);
        chk("eastTx", eastTxData, (dBit & !mWest) ? txLevel : 1'b1);
        chk("westTx", westTxData, (dBit & mWest) ? txLevel : 1'b1);
      end
    end
  end

  int tS[7] = '{23, 23, 1, 1, 24, 0, 25};
  int tC[7] = '{2, 3, 24, 24, 1, 1, 1};
  logic t64[7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic ok;

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (100) @(posedge clk);
    // reset values, reserved bits and an unmapped place
    busCycle(1'b0, `REG_CTRL, 32'h0);
    chk("ctrlReset", rd, 32'h0000_0000);
    busCycle(1'b0, `REG_SLOT, 32'h0);
    chk("slotReset", rd, 32'h0000_0101);
    busCycle(1'b0, `REG_RATE, 32'h0);
    chk("rateReset", rd, {21'h0, `ROOT_56});
    busCycle(1'b1, `REG_CTRL, 32'hFFFF_FFFF);
    busCycle(1'b0, `REG_CTRL, 32'h0);
    chk("ctrlReserved", rd, 32'h0000_000F);
    busCycle(1'b0, 5'h18, 32'h0);
    chk("unmapped", rd, 32'h0);
    // rate and validity over boundary settings
    for (int k = 0; k < 7; k++) begin
      cfg(1'b0, t64[k], 1'b0, 1'b0, tS[k], tC[k]);
      ok = tS[k] >= 1 && tS[k] <= 24 && tC[k] >= 1 && tS[k] + tC[k] <= 25;
      busCycle(1'b0, `REG_RATE, 32'h0);
      chk("rate", rd, ok ? tC[k] * (t64[k] ? `ROOT_64 : `ROOT_56) : 0);
      busCycle(1'b0, `REG_STATUS, 32'h0);
      chk("invalid", rd[`STAT_INVALID], !ok);
    end
    // east, 56k, internal clock, slots 3 to 7 overlapping slots 5 and 6
    busCycle(1'b1, `REG_EAST_USED, 32'h0000_0030);
    busCycle(1'b1, `REG_WEST_USED, 32'h0080_0000);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 3, 5);
    busCycle(1'b0, `REG_STATUS, 32'h0);
    chk("conflictEast", rd[23:0], 24'h000030);
    linkRun(35);
    // west, 64k, external clock, slots 21 to 24 at the frame end
    cfg(1'b1, 1'b1, 1'b1, 1'b1, 21, 4);
    busCycle(1'b0, `REG_STATUS, 32'h0);
    chk("conflictWest", rd[23:0], 24'h800000);
    linkRun(0);
    // the model gives one clock edge per frame, so bits go missing
    busCycle(1'b0, `REG_STATUS, 32'h0);
    chk("underrun", rd[`STAT_UNDER], 32'h1);
    // disabled channel occupies no slot
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 1, 24);
    mCount = 0;
    linkRun(0);
    // no data bits consumed now, so the sticky flag clears and stays clear
    busCycle(1'b1, `REG_STATUS, 32'h0400_0000);
    busCycle(1'b0, `REG_STATUS, 32'h0);
    chk("underClear", rd[`STAT_UNDER], 32'h0);
    give_verdict();
  end

  // watchdog
  initial begin
    #300000;
    nMismatch++;
    give_verdict();
  end
endmodule
